// >>> rtl/timer_flags_prescaler.sv
// Timer status flags, shared prescaler, clock select and external pin clocking.
//
// Behaviour
// - Capture flag one sets on capture or top.
// - Vector execution or write-one clears a flag.
// - Compare flags set one timer tick after match.
// - Forced compare strobes never set compare flags.
// - Overflow flag one follows mode-resolved overflow event.
// - Overflow flag three follows its mode-resolved event.
// - Extended register holds timer-three flags plus C1.
// - One prescaler, per-timer tap choice.
// - Select one clocks timer every system cycle.
// - Taps divide by 8, 64, 256, 1024.
// - Prescaler runs free of clock selects.
// - Prescaler reset restarts all three timers' periods.
// - Pin sampled each cycle through synchroniser.
// - Select 7 rising edges, 6 falling edges.
// - Pin edge reaches counter in few cycles.
// - External edges bypass the prescaler.
// - Sync mode keeps written prescaler reset bits.
// - Clearing sync mode clears reset bits.
// - Shared reset bit clears itself outside sync.
// - Select zero stops the timer.
//
// The block keeps the status flags of both 16-bit timers, the prescaler that all three
// timers draw their ticks from, the per-timer clock select and the external pin clocks.
// Counters, comparators and capture registers live outside the block. They hand in
// one-cycle event pulses and level compare results on the system clock.
// Hazards worth knowing:
// - A flag set and its clear in one cycle keep the flag, so no event is lost.
// - The shared prescaler reset gates every tap at once, so all timers restart their
//   prescaled period together.
// - The pin path samples the pin once per cycle, on the falling edge; a pin whose half period is not longer
//   than one clock cycle will lose edges.
// - Reserved flag bits are never set, so they read zero whatever software writes.
`timescale 1ns/10ps
module timer_flags_prescaler
   import timer_flags_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rstn,
   // Register port.
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   output logic      [7:0] rdata,
   // External timer clock pins, index 0 timer one, 1 timer two, 2 timer three.
   input  wire logic [2:0] ext_timer_clock_pin,
   // Timer-one datapath events.
   input  wire logic       capture_evt_t1,
   input  wire logic       top_reach_t1,
   input  wire logic [3:0] waveform_mode_field_t1,
   input  wire logic [2:0] cmp_eq_t1,
   input  wire logic       overflow_evt_t1,
   // Timer-three datapath events.
   input  wire logic       capture_evt_t3,
   input  wire logic       top_reach_t3,
   input  wire logic [3:0] waveform_mode_field_t3,
   input  wire logic [2:0] cmp_eq_t3,
   input  wire logic       overflow_evt_t3,
   // Interrupt vector execution acknowledges.
   input  wire logic [7:0] vector_ack_one,
   input  wire logic [7:0] vector_ack_ext,
   // Timer clock ticks.
   output logic            timer_one_tick,
   output logic            timer_two_tick,
   output logic            timer_three_tick,
   // Prescaler reset levels.
   output logic            shared_prescaler_reset,
   output logic            aux_prescaler_reset,
   // Flag register contents for the interrupt controller.
   output logic      [7:0] flags_one,
   output logic      [7:0] flags_ext
);
   // Read data register.
   logic [7:0] rdata_r;
   // Synchronisation mode bit.
   logic       sync_mode_bit_r;
   // Shared and auxiliary prescaler reset bits.
   logic       psr_shared_r;
   logic       psr_aux_r;
   // Clock select fields per timer.
   logic [2:0] cs_r [3];
   // Shared prescaler count.
   logic [9:0] presc_r;
   // Prescaler taps, one-cycle pulses.
   logic [3:0] tap;
   // Tick registers per timer.
   logic [2:0] tick_r;
   // Next tick values per timer.
   logic [2:0] tick_nxt;
   // Edge pulses from the pin detectors.
   logic [2:0] ext_edge;
   // Compare matches seen at the previous tick, t1 then t3.
   logic [2:0] seen_t1_r;
   logic [2:0] seen_t3_r;
   // Capture-as-top mode flags.
   logic       cap_top_t1;
   logic       cap_top_t3;
   // Set vectors for the two flag registers.
   logic [7:0] set_one;
   logic [7:0] set_ext;
   // Write-one clear vectors.
   logic [7:0] clr_one;
   logic [7:0] clr_ext;
   // Address decodes.
   logic       wr_one;
   logic       wr_ext;
   logic       wr_sfc;
   logic       wr_cs1;
   logic       wr_cs2;
   // Read mux output.
   logic [7:0] rd_mux;
   // Flag state from the sticky banks.
   logic [7:0] f_one;
   logic [7:0] f_ext;

   // Write decodes.
   assign wr_one = wr_stb && (addr == ADDR_FLAGS_ONE);
   assign wr_ext = wr_stb && (addr == ADDR_FLAGS_EXT);
   assign wr_sfc = wr_stb && (addr == ADDR_SFC);
   assign wr_cs1 = wr_stb && (addr == ADDR_CS_ONE);
   assign wr_cs2 = wr_stb && (addr == ADDR_CS_TWO);

   // Only implemented flag bits can be cleared; reserved bits ignore writes.
   assign clr_one = wr_one ? (wdata & 8'h3C) : 8'h00;
   assign clr_ext = wr_ext ? (wdata & 8'h3F) : 8'h00;

   // Capture register acts as top in these waveform modes.
   // In those modes the capture pin is ignored and only reaching top sets the flag.
   assign cap_top_t1 = (waveform_mode_field_t1 == WM_CAP_TOP_A) || (waveform_mode_field_t1 == WM_CAP_TOP_B)
                    || (waveform_mode_field_t1 == WM_CAP_TOP_C) || (waveform_mode_field_t1 == WM_CAP_TOP_D);
   assign cap_top_t3 = (waveform_mode_field_t3 == WM_CAP_TOP_A) || (waveform_mode_field_t3 == WM_CAP_TOP_B)
                    || (waveform_mode_field_t3 == WM_CAP_TOP_C) || (waveform_mode_field_t3 == WM_CAP_TOP_D);

   // Timer-one set events; force strobes are not inputs here, so they never set flags.
   always_comb begin
      set_one         = 8'h00;
      // Capture source depends on whether the capture register is the top value.
      set_one[F1_CAP] = cap_top_t1 ? top_reach_t1 : capture_evt_t1;
      // Compare flags use the match seen at the previous tick.
      set_one[F1_CMPA] = tick_r[0] & seen_t1_r[0];
      set_one[F1_CMPB] = tick_r[0] & seen_t1_r[1];
      // Overflow arrives already resolved for the waveform mode.
      set_one[F1_OVF] = overflow_evt_t1;
   end

   // Extended register set events.
   always_comb begin
      set_ext           = 8'h00;
      // Timer-three capture follows the same top rule as timer one.
      set_ext[FX_CAP3]  = cap_top_t3 ? top_reach_t3 : capture_evt_t3;
      // Timer-three compare flags step on timer-three ticks.
      set_ext[FX_CMPA3] = tick_r[2] & seen_t3_r[0];
      set_ext[FX_CMPB3] = tick_r[2] & seen_t3_r[1];
      // Overflow arrives already resolved for the waveform mode.
      set_ext[FX_OVF3]  = overflow_evt_t3;
      set_ext[FX_CMPC3] = tick_r[2] & seen_t3_r[2];
      // Timer-one channel C lives here and steps on timer-one ticks.
      set_ext[FX_CMPC1] = tick_r[0] & seen_t1_r[2];
   end

   // Sticky bank for the timer-one flag register.
   // Vector acknowledge and write-one clear share the clear side of the bank.
   sticky_flags #(
      .W(8)
   ) u_flags_one (
      .clk    (clk),
      .rstn   (rstn),
      .set    (set_one & 8'h3C),
      .hw_clr (vector_ack_one),
      .sw_clr (clr_one),
      .q      (f_one)
   );

   // Sticky bank for the extended flag register.
   // Only the low six bits can ever be set; the top two stay zero.
   sticky_flags #(
      .W(8)
   ) u_flags_ext (
      .clk    (clk),
      .rstn   (rstn),
      .set    (set_ext & 8'h3F),
      .hw_clr (vector_ack_ext),
      .sw_clr (clr_ext),
      .q      (f_ext)
   );

   // Latch the comparator state at each timer tick so the flag sets at the next tick.
   // Matches seen between ticks are ignored, as the counter has not moved then.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seen_t1_r <= 3'h0;
         seen_t3_r <= 3'h0;
      end else begin
         if (tick_r[0]) begin
            seen_t1_r <= cmp_eq_t1;
         end
         if (tick_r[2]) begin
            seen_t3_r <= cmp_eq_t3;
         end
      end
   end

   // Special function control: sync mode keeps reset bits, otherwise they self-clear.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_mode_bit_r <= 1'b0;
         psr_shared_r    <= 1'b0;
         psr_aux_r       <= 1'b0;
      end else if (wr_sfc) begin
         // A write loads the mode and both reset bits together.
         sync_mode_bit_r <= wdata[SF_SYNC];
         psr_shared_r    <= wdata[SF_SHARED];
         psr_aux_r       <= wdata[SF_AUX];
      end else if (!sync_mode_bit_r) begin
         // Outside sync mode the reset bits last one cycle only.
         psr_shared_r <= 1'b0;
         psr_aux_r    <= 1'b0;
      end
   end

   // Clock select fields.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cs_r[0] <= RST_CS;
         cs_r[1] <= RST_CS;
         cs_r[2] <= RST_CS;
      end else begin
         if (wr_cs1) begin
            // Timer one and timer three share one select register.
            cs_r[0] <= wdata[CS_T1_LSB +: 3];
            cs_r[2] <= wdata[CS_T3_LSB +: 3];
         end
         if (wr_cs2) begin
            cs_r[1] <= wdata[CS_T2_LSB +: 3];
         end
      end
   end

   // Free-running prescaler, held at zero while the shared reset bit stands.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         presc_r <= RST_PRESC;
      end else if (psr_shared_r) begin
         // Holding at zero restarts the period seen by every timer.
         presc_r <= RST_PRESC;
      end else begin
         presc_r <= presc_r + 10'h001;
      end
   end

   // A tap pulses when its low count bits are all ones.
   // Taps are gated while the reset bit stands, so a held prescaler gives no tick.
   assign tap[0] = !psr_shared_r && (&presc_r[TAP8_W-1:0]);
   assign tap[1] = !psr_shared_r && (&presc_r[TAP64_W-1:0]);
   assign tap[2] = !psr_shared_r && (&presc_r[TAP256_W-1:0]);
   assign tap[3] = !psr_shared_r && (&presc_r[TAP1024_W-1:0]);

   // Per-timer clock select: pin detector and tap choice.
   for (genvar t = 0; t < 3; t++) begin : g_sel
      pin_edge_detect u_edge (
         .clk        (clk),
         .rstn       (rstn),
         .pin        (ext_timer_clock_pin[t]),
         .rise_sel   (cs_r[t] == CS_EXT_RISE),
         .edge_pulse (ext_edge[t])
      );

      // Each timer picks its own source from the shared taps.
      always_comb begin
         unique case (cs_r[t])
            CS_STOP:     tick_nxt[t] = 1'b0;
            CS_DIRECT:   tick_nxt[t] = 1'b1;
            CS_DIV8:     tick_nxt[t] = tap[0];
            CS_DIV64:    tick_nxt[t] = tap[1];
            CS_DIV256:   tick_nxt[t] = tap[2];
            CS_DIV1024:  tick_nxt[t] = tap[3];
            CS_EXT_FALL: tick_nxt[t] = ext_edge[t];
            CS_EXT_RISE: tick_nxt[t] = ext_edge[t];
         endcase
      end
   end

   // Register the ticks so the timers see clean one-cycle pulses.
   // For the pin path this register completes the synchroniser latency, and the
   // counter moves on the edge that ends the tick cycle.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_r <= 3'h0;
      end else begin
         tick_r <= tick_nxt;
      end
   end

   // Read multiplexer; reserved and unmapped bits read zero.
   always_comb begin
      rd_mux = RST_BYTE;
      unique case (addr)
         ADDR_FLAGS_ONE: rd_mux = f_one & 8'h3C;
         ADDR_FLAGS_EXT: rd_mux = f_ext & 8'h3F;
         ADDR_SFC: begin
            // Control bits read back as stored, so software sees a held reset.
            rd_mux[SF_SYNC]   = sync_mode_bit_r;
            rd_mux[SF_AUX]    = psr_aux_r;
            rd_mux[SF_SHARED] = psr_shared_r;
         end
         ADDR_CS_ONE: begin
            rd_mux[CS_T1_LSB +: 3] = cs_r[0];
            rd_mux[CS_T3_LSB +: 3] = cs_r[2];
         end
         ADDR_CS_TWO: rd_mux[CS_T2_LSB +: 3] = cs_r[1];
         default: rd_mux = RST_BYTE;
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   // Reading has no side effect; flags clear only by a write of one or a vector.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= RST_BYTE;
      end else begin
         rdata_r <= rd_stb ? rd_mux : RST_BYTE;
      end
   end

   // Outputs straight from flip-flops.
   assign rdata                  = rdata_r;
   assign timer_one_tick         = tick_r[0];
   assign timer_two_tick         = tick_r[1];
   assign timer_three_tick       = tick_r[2];
   assign shared_prescaler_reset = psr_shared_r;
   assign aux_prescaler_reset    = psr_aux_r;
   // Unused flag bits are never set and reset to zero, so no mask is needed here.
   assign flags_one              = f_one;
   assign flags_ext              = f_ext;
endmodule // timer_flags_prescaler

// >>> rtl/timer_flags_pkg.sv
// Shared constants for the timer flag and shared prescaler block.
package timer_flags_pkg;
   // Register indices on the 8-bit register port.
   localparam logic [2:0] ADDR_FLAGS_ONE = 3'h0;
   localparam logic [2:0] ADDR_FLAGS_EXT = 3'h1;
   localparam logic [2:0] ADDR_SFC       = 3'h2;
   localparam logic [2:0] ADDR_CS_ONE    = 3'h3;
   localparam logic [2:0] ADDR_CS_TWO    = 3'h4;
   // Field positions in the timer-one flag register.
   localparam int F1_CAP = 5;
   localparam int F1_CMPA = 4;
   localparam int F1_CMPB = 3;
   localparam int F1_OVF = 2;
   // Field positions in the extended flag register.
   localparam int FX_CAP3 = 5;
   localparam int FX_CMPA3 = 4;
   localparam int FX_CMPB3 = 3;
   localparam int FX_OVF3 = 2;
   localparam int FX_CMPC3 = 1;
   localparam int FX_CMPC1 = 0;
   // Field positions in the special function control register.
   localparam int SF_SYNC = 7;
   localparam int SF_AUX = 1;
   localparam int SF_SHARED = 0;
   // Clock select field positions in the clock select registers.
   localparam int CS_T1_LSB = 0;
   localparam int CS_T3_LSB = 3;
   localparam int CS_T2_LSB = 0;
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_CS = 3'h0;
   localparam logic [9:0] RST_PRESC = 10'h000;
   // Clock select codes.
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIRECT = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   // Prescaler tap widths: divisor is two to this power.
   localparam int TAP8_W = 3;
   localparam int TAP64_W = 6;
   localparam int TAP256_W = 8;
   localparam int TAP1024_W = 10;
   // Waveform modes in which the capture register sets the top value.
   localparam logic [3:0] WM_CAP_TOP_A = 4'h8;
   localparam logic [3:0] WM_CAP_TOP_B = 4'hA;
   localparam logic [3:0] WM_CAP_TOP_C = 4'hC;
   localparam logic [3:0] WM_CAP_TOP_D = 4'hE;
endpackage

// >>> rtl/sticky_flags.sv
// Sticky event flags with vector-acknowledge and write-one clear.
`timescale 1ns/10ps
module sticky_flags #(
   parameter int W = 4
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rstn,
   // Set and clear requests.
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] hw_clr,
   input  wire logic [W-1:0] sw_clr,
   // Flag state.
   output logic      [W-1:0] q
);
   // Next flag value; a set in the clearing cycle wins.
   logic [W-1:0] q_nxt;

   assign q_nxt = set | (q & ~(hw_clr | sw_clr));

   // Flags start cleared.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= q_nxt;
      end
   end
endmodule // sticky_flags

// >>> rtl/pin_edge_detect.sv
// Two-stage synchroniser and edge detector for an external timer clock pin.
`timescale 1ns/10ps
module pin_edge_detect (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rstn,
   // Pin and edge choice.
   input  wire logic pin,
   input  wire logic rise_sel,
   // One-cycle edge pulse, combinational from the synchronised history.
   output logic      edge_pulse
);
   // First stage stands for the clock-high transparent latch.
   logic s1_r;
   // Second stage is the synchronised pin level.
   logic s2_r;
   // History of the synchronised level.
   logic hist_r;

   // First stage closes on the falling edge, like a latch open while the clock is high.
   always_ff @(negedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_r <= 1'b0;
      end else begin
         s1_r <= pin;
      end
   end

   // Second stage and history sample on every rising clock edge.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s2_r   <= 1'b0;
         hist_r <= 1'b0;
      end else begin
         s2_r   <= s1_r;
         hist_r <= s2_r;
      end
   end

   // One pulse per rising or falling edge as chosen.
   assign edge_pulse = rise_sel ? (s2_r & ~hist_r) : (~s2_r & hist_r);
endmodule // pin_edge_detect

// >>> bench/tfp_chk.sv
// Port-level assertions for the timer flag and shared prescaler block.
`timescale 1ns/10ps
module tfp_chk
   import timer_flags_pkg::*;
(
   // Clock and reset.
   input wire logic       clk,
   input wire logic       rstn,
   // Register port.
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_stb,
   // Datapath events.
   input wire logic       capture_evt_t1,
   input wire logic [3:0] waveform_mode_field_t1,
   input wire logic       overflow_evt_t1,
   input wire logic       capture_evt_t3,
   input wire logic [3:0] waveform_mode_field_t3,
   input wire logic       overflow_evt_t3,
   // Watched outputs.
   input wire logic       shared_prescaler_reset,
   input wire logic [7:0] flags_one,
   input wire logic [7:0] flags_ext
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // A capture counts only outside the modes where the capture register is top.
   wire cap1_ok = capture_evt_t1 && !(waveform_mode_field_t1[3] && !waveform_mode_field_t1[0]);
   wire cap3_ok = capture_evt_t3 && !(waveform_mode_field_t3[3] && !waveform_mode_field_t3[0]);
   property p_ovf1; overflow_evt_t1 |=> flags_one[F1_OVF]; endproperty
   a_ovf1: assert property (p_ovf1) else $error("overflow one flag not set");
   property p_ovf3; overflow_evt_t3 |=> flags_ext[FX_OVF3]; endproperty
   a_ovf3: assert property (p_ovf3) else $error("overflow three flag not set");
   property p_cap1; cap1_ok |=> flags_one[F1_CAP]; endproperty
   a_cap1: assert property (p_cap1) else $error("capture one flag not set");
   property p_cap3; cap3_ok |=> flags_ext[FX_CAP3]; endproperty
   a_cap3: assert property (p_cap3) else $error("capture three flag not set");
   property p_w1c;
      wr_stb && addr == ADDR_FLAGS_ONE && wdata[F1_OVF] && !overflow_evt_t1 |=> !flags_one[F1_OVF];
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear");
   property p_rsv; flags_one[7:6] == 2'b00 && flags_ext[7:6] == 2'b00; endproperty
   a_rsv: assert property (p_rsv) else $error("top flag bits not zero");
   property p_spulse;
      (wr_stb && addr == ADDR_SFC && wdata == 8'h01) ##1 !wr_stb
         |-> shared_prescaler_reset ##1 !shared_prescaler_reset;
   endproperty
   a_spulse: assert property (p_spulse) else $error("shared reset not one cycle");
   // Mirror of the sync mode bit, taken from writes to the control register.
   logic sync_seen_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_seen_r <= 1'b0;
      end else if (wr_stb && addr == ADDR_SFC) begin
         sync_seen_r <= wdata[SF_SYNC];
      end
   end
   property p_shold;
      sync_seen_r && shared_prescaler_reset && !(wr_stb && addr == ADDR_SFC)
         |=> shared_prescaler_reset;
   endproperty
   a_shold: assert property (p_shold) else $error("held reset dropped");
   property p_rise; $rose(flags_one[F1_OVF]) |-> $past(overflow_evt_t1); endproperty
   a_rise: assert property (p_rise) else $error("overflow flag rose without event");
   // Main scenarios reached.
   c_setclr: cover property (overflow_evt_t1 && wr_stb && addr == ADDR_FLAGS_ONE);
   c_hold: cover property (shared_prescaler_reset [*3]);
   c_captop: cover property (capture_evt_t1 && waveform_mode_field_t1 == WM_CAP_TOP_A);
endmodule // tfp_chk

// >>> bench/pin_source.sv
// Model of an external clock source on a timer clock pin.
`timescale 1ns/10ps
module pin_source #(
   parameter int HALF_NS = 24   // Half period: three system cycles.
) (
   // Burst enable.
   input wire logic run,
   // Pin level.
   output logic     pin
);
   // Pin rests low and toggles only while running, so it is still between bursts.
   // Each half period outlasts a system cycle, well under the sampling limit.
   // The offset keeps pin edges away from both clock edges.
   initial begin
      pin = 1'b0;
      #2;
      forever #(HALF_NS) if (run) pin = ~pin;
   end
endmodule // pin_source

// >>> bench/tb_timer_flags_prescaler.sv
// Self-checking bench for the timer flag and shared prescaler block.
`timescale 1ns/10ps
module tb_timer_flags_prescaler
   import timer_flags_pkg::*;
;
   logic       clk, rstn, wr_stb, rd_stb, run, pin0;
   logic [2:0] addr, eq1, eq3;
   logic [7:0] wdata, rdata, ack1, f1, fx;
   logic [5:0] ev;      // Events: cap1, top1, ovf1, cap3, top3, ovf3.
   logic [3:0] wm1;     // Waveform mode of timer one.
   logic       tk1, tk2, tk3, spr, apr;
   int         miscompares, tests_run, rises, falls, tsum;
   timer_flags_prescaler DUT (.clk, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
      .ext_timer_clock_pin({2'b00, pin0}), .capture_evt_t1(ev[0]), .top_reach_t1(ev[1]),
      .waveform_mode_field_t1(wm1), .cmp_eq_t1(eq1), .overflow_evt_t1(ev[2]),
      .capture_evt_t3(ev[3]), .top_reach_t3(ev[4]), .waveform_mode_field_t3(4'h0),
      .cmp_eq_t3(eq3), .overflow_evt_t3(ev[5]), .vector_ack_one(ack1), .vector_ack_ext(8'h00),
      .timer_one_tick(tk1), .timer_two_tick(tk2), .timer_three_tick(tk3),
      .shared_prescaler_reset(spr), .aux_prescaler_reset(apr), .flags_one(f1), .flags_ext(fx));
   pin_source src (.run, .pin(pin0));
   // Clock and edge tallies.
   always #4 clk = ~clk;
   always @(posedge pin0) rises++;
   always @(negedge pin0) falls++;
   always @(posedge clk) if (tk1 === 1'b1) tsum++;
   // Compares a value with its expectation.
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   // Read data stand in the cycle after the strobe.
   task rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task pulse(input logic [5:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 6'h00;
   endtask
   // Counts ticks of each timer over n cycles.
   task cnt(input int n, output int c1, output int c2, output int c3);
      c1 = 0;
      c2 = 0;
      c3 = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         c1 += (tk1 === 1'b1);
         c2 += (tk2 === 1'b1);
         c3 += (tk3 === 1'b1);
      end
   endtask
   task s_ovf;
      rd(3'h7, 8'h00);
      rd(ADDR_SFC, 8'h00);
      pulse(6'h04);
      rd(ADDR_FLAGS_ONE, 8'h04);
      wr(ADDR_FLAGS_ONE, 8'h00);
      rd(ADDR_FLAGS_ONE, 8'h04);
      // Set and write-one clear in the same cycle.
      @(posedge clk);
      ev <= 6'h04;
      addr <= ADDR_FLAGS_ONE;
      wdata <= 8'h04;
      wr_stb <= 1'b1;
      @(posedge clk);
      ev <= 6'h00;
      wr_stb <= 1'b0;
      rd(ADDR_FLAGS_ONE, 8'h04);
      wr(ADDR_FLAGS_ONE, 8'h04);
      rd(ADDR_FLAGS_ONE, 8'h00);
      pulse(6'h04);
      @(posedge clk);
      ack1 <= 8'h04;
      @(posedge clk);
      ack1 <= 8'h00;
      #1 chk(f1, 8'h00);
      pulse(6'h20);
      rd(ADDR_FLAGS_EXT, 8'h04);
      wr(ADDR_FLAGS_EXT, 8'h04);
   endtask
   task s_cap;
      pulse(6'h01);
      #1 chk(f1, 8'h20);
      wr(ADDR_FLAGS_ONE, 8'h20);
      // Every mode with the capture register as top ignores the capture pin.
      for (int m = 0; m < 4; m++) begin
         wm1 <= 4'(WM_CAP_TOP_A + 2 * m);
         pulse(6'h01);
         #1 chk(f1, 8'h00);
         pulse(6'h02);
         #1 chk(f1, 8'h20);
         wr(ADDR_FLAGS_ONE, 8'h20);
      end
      wm1 <= 4'h0;
      pulse(6'h08);
      #1 chk(fx, 8'h20);
      wr(ADDR_FLAGS_EXT, 8'h20);
      #1 chk(fx, 8'h00);
   endtask
   task s_cmp(input logic [2:0] cs, input logic [7:0] e1, input logic [7:0] ex);
      wr(ADDR_CS_ONE, {2'b00, cs, cs});
      repeat (3) @(posedge clk);
      eq1 <= 3'h7;
      eq3 <= 3'h7;
      @(posedge clk);
      eq1 <= 3'h0;
      eq3 <= 3'h0;
      #1 chk(f1, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk(f1, e1);
      chk(fx, ex);
      wr(ADDR_FLAGS_ONE, 8'h18);
      wr(ADDR_FLAGS_EXT, 8'h1B);
   endtask
   task s_taps;
      int dv[6] = '{0, 1, 8, 64, 256, 1024};
      int c1, c2, c3, w, e;
      for (int k = 0; k < 6; k++) begin
         wr(ADDR_CS_ONE, {2'b00, k[2:0], k[2:0]});
         wr(ADDR_CS_TWO, {5'h00, k[2:0]});
         repeat (4) @(posedge clk);
         w = (dv[k] < 8) ? 16 : 2 * dv[k];
         e = (dv[k] == 0) ? 0 : w / dv[k];
         cnt(w, c1, c2, c3);
         chk(c1, e);
         chk(c2, e);
         chk(c3, e);
      end
   endtask
   task s_sync;
      int c1, c2, c3;
      wr(ADDR_CS_ONE, {2'b00, CS_DIV8, CS_DIV8});
      wr(ADDR_CS_TWO, {5'h00, CS_DIV8});
      wr(ADDR_SFC, 8'h83);
      cnt(40, c1, c2, c3);
      chk(c1 + c2 + c3, 0);
      chk(spr, 1'b1);
      chk(apr, 1'b1);
      rd(ADDR_SFC, 8'h83);
      wr(ADDR_SFC, 8'h00);
      #1 chk(spr, 1'b0);
      chk(apr, 1'b0);
      cnt(20, c1, c2, c3);
      chk(c1, 2);
      chk(c2, 2);
      chk(c3, 2);
      wr(ADDR_SFC, 8'h01);
      #1 chk(spr, 1'b1);
      @(posedge clk);
      #1 chk(spr, 1'b0);
   endtask
   // Pin bursts while the pin is still at enable time.
   task s_ext(input logic [2:0] cs, input bit fall);
      wr(ADDR_CS_ONE, {5'h00, cs});
      #1;
      rises = 0;
      falls = 0;
      tsum = 0;
      run <= 1'b1;
      repeat (60) @(posedge clk);
      run <= 1'b0;
      repeat (8) @(posedge clk);
      chk(tsum, fall ? falls : rises);
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {clk, rstn, wr_stb, rd_stb, run, addr, eq1, eq3, wdata, ack1, ev, wm1} = '0;
      {miscompares, tests_run, rises, falls, tsum} = '0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      s_ovf;
      s_cap;
      s_cmp(CS_DIRECT, 8'h18, 8'h1B);
      s_cmp(CS_STOP, 8'h00, 8'h00);
      s_taps;
      s_sync;
      s_ext(CS_EXT_RISE, 1'b0);
      s_ext(CS_EXT_FALL, 1'b1);
      wrap_up;
   end
   // Cuts a hang short.
   initial begin
      #400000;
      miscompares++;
      wrap_up;
   end
endmodule // tb_timer_flags_prescaler
bind timer_flags_prescaler tfp_chk chk_i (.clk, .rstn, .addr, .wdata, .wr_stb, .capture_evt_t1,
   .waveform_mode_field_t1, .overflow_evt_t1, .capture_evt_t3, .waveform_mode_field_t3,
   .overflow_evt_t3, .shared_prescaler_reset, .flags_one, .flags_ext);
